// [bench/sase_exec_asserts.sv]
// Port-level checks for the execution unit, bound to its top module
`timescale 1ns/1ns
module sase_exec_asserts
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic instrValid,
    input wire logic [31:0] instrWord,
    input wire logic instrReady,
    input wire logic [8:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdData,
    input wire logic storeValid,
    input wire logic storeReady,
    input wire logic [31:0] storeAddr,
    input wire logic [31:0] storeData,
    input wire logic [6:0] storeCntl,
    input wire logic storeCop,
    input wire logic busHold
);
    // Instruction taken this cycle and its opcode pair
    wire takeIn = instrValid && instrReady;
    wire [6:0] opPair = instrWord[31:25];
    // All three store forms hold off further issue
    wire isStore = opPair == sase_pkg::OpStore || opPair == sase_pkg::OpLockedWrite
        || opPair == sase_pkg::OpMultiWordWrite;
    // Everything the taker sees of the head word
    wire [72:0] headWord = {storeAddr, storeData, storeCntl, storeCop, busHold};

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    store_busy_a: assert property (takeIn && isStore |=> !instrReady)
        else $error("store did not stop issue");
    alu_free_a: assert property (takeIn && !isStore |=> instrReady)
        else $error("non-store held issue");
    store_out_a: assert property (takeIn && isStore |-> ##[1:4] storeValid)
        else $error("store word never offered");
    // A stalled word must not change under the taker
    head_hold_a: assert property (storeValid && !storeReady |=>
        storeValid && $stable(headWord))
        else $error("head word changed while stalled");
    // Empty buffer: the locked word is at the head two cycles on
    lock_head_a: assert property (takeIn && opPair == sase_pkg::OpLockedWrite && !storeValid
        |-> ##2 storeValid && busHold && storeCntl == $past(instrWord[22:16], 2))
        else $error("locked word lacks hold or control");
    plain_head_a: assert property (takeIn && opPair == sase_pkg::OpStore && !storeValid
        |-> ##2 storeValid && !busHold && storeCop == $past(instrWord[23], 2))
        else $error("plain store word wrong");
    lock_only_a: assert property (busHold |-> storeValid)
        else $error("bus hold without a word");
    rd_idle_a: assert property (!$past(regRd) |-> regRdData == 32'h0000_0000)
        else $error("read data outside its cycle");
    reset_quiet_a: assert property ($rose(rst_n) |-> !storeValid && !instrReady)
        else $error("outputs busy out of reset");

    cover property (takeIn && opPair == sase_pkg::OpMultiWordWrite);
    cover property (storeValid && !storeReady ##1 storeValid && storeReady);
    cover property (busHold && storeCop);
endmodule // sase_exec_asserts

bind sase_exec sase_exec_asserts sase_exec_asserts_i
(
    .clk(clk), .rst_n(rst_n), .instrValid(instrValid), .instrWord(instrWord),
    .instrReady(instrReady), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .storeValid(storeValid), .storeReady(storeReady),
    .storeAddr(storeAddr), .storeData(storeData), .storeCntl(storeCntl),
    .storeCop(storeCop), .busHold(busHold)
);

// [bench/sase_exec_tb.sv]
// Self-checking bench: register, ALU and store sequences
`timescale 1ns/1ns
module sase_exec_tb;
    logic clk, rst_n, instrValid, instrReady, regWr, regRd, storeValid, storeReady;
    logic [31:0] instrWord, regWrData, regRdData, storeAddr, storeData;
    logic [8:0] regAddr;
    logic [6:0] storeCntl;
    logic storeCop, busHold;
    logic slowMode; // Taker accepts one cycle in four
    int bad_count, cmp_count, cycleCount;

    sase_exec sase_exec_i
    (
        .clk(clk), .rst_n(rst_n), .instrValid(instrValid), .instrWord(instrWord),
        .instrReady(instrReady), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .storeValid(storeValid),
        .storeReady(storeReady), .storeAddr(storeAddr), .storeData(storeData),
        .storeCntl(storeCntl), .storeCop(storeCop), .busHold(busHold)
    );

    sase_store_taker sase_store_taker_i
    (
        .clk(clk), .rst_n(rst_n), .slow(slowMode), .storeValid(storeValid),
        .storeReady(storeReady), .storeAddr(storeAddr), .storeData(storeData),
        .storeCntl(storeCntl), .storeCop(storeCop), .busHold(busHold)
    );

    // 125 MHz clock
    initial
    begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    // Counts and verdict; the only place the run ends
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [72:0] seen, input logic [72:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t ns: seen %h, expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle write strobe
    task automatic reg_wr(input logic [8:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'h1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'h0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [8:0] a, input logic [31:0] e);
        @(posedge clk);
        regRd <= 1'h1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'h0;
        #1;
        check(73'(regRdData), 73'(e));
    endtask

    // Waits for issue to open, then offers one instruction
    task automatic issue(input logic [31:0] w);
        int n;
        n = 0;
        while (instrReady !== 1'h1 && n < 100)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        instrValid <= 1'h1;
        instrWord <= w;
        @(posedge clk);
        instrValid <= 1'h0;
        #1;
    endtask

    // Next word seen by the taker; all-ones address means no defined meaning
    task automatic take(input logic [31:0] a, d, input logic [6:0] c, input logic cp, lk);
        sase_pkg::sase_word_type g;
        int n;
        n = 0;
        while (sase_store_taker_i.got.size() == 0 && n < 200)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        g = sase_store_taker_i.got.pop_front();
        if (a == 32'hFFFF_FFFF)
            g.addr = a;
        check(g, {a, d, c, cp, lk});
    endtask

    // Hang guard, well above the hundred or so cycles the run needs
    always @(posedge clk)
    begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == 20000)
        begin
            bad_count++;
            finish_test();
        end
    end

    initial
    begin
        rst_n = 1'h0;
        instrValid = 1'h0;
        instrWord = 32'h0;
        regAddr = 9'h0;
        regWrData = 32'h0;
        regWr = 1'h0;
        regRd = 1'h0;
        slowMode = 1'h0;
        bad_count = 0;
        cmp_count = 0;
        cycleCount = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'h1;
        reg_wr(9'h001, 32'h0000_0005);
        reg_wr(9'h002, 32'h0000_0007);
        reg_wr(9'h003, 32'hF000_0001);
        reg_wr(9'h005, 32'h8000_0000);
        reg_rd(9'h1FF, 32'h0); // Unmapped index reads zero
        // Shifts: literal count, then register count
        issue({8'h83, 8'h06, 8'h03, 8'h04});
        reg_rd(9'h006, 32'h0F00_0000);
        issue({8'h82, 8'h07, 8'h03, 8'h02});
        reg_rd(9'h007, 32'h01E0_0000);
        issue(32'hFF06_0101); // Unknown opcode leaves target alone
        reg_rd(9'h006, 32'h0F00_0000);
        // Subtracts with borrow, zero and overflow outcomes
        issue({8'h24, 8'h08, 8'h01, 8'h02});
        reg_rd(9'h008, 32'hFFFF_FFFE);
        reg_rd(sase_pkg::RegAluStatus, 32'h4);
        issue({8'h2D, 8'h09, 8'h01, 8'h04});
        reg_rd(9'h009, 32'h0);
        reg_rd(sase_pkg::RegAluStatus, 32'h3);
        issue({8'h2C, 8'h0A, 8'h01, 8'h02});
        reg_rd(9'h00A, 32'hFFFF_FFFE);
        issue({8'h25, 8'h0B, 8'h05, 8'h01});
        reg_rd(9'h00B, 32'h7FFF_FFFF);
        reg_rd(sase_pkg::RegAluStatus, 32'h9);
        // Single, literal, coprocessor and locked stores
        issue({8'h1E, 8'h55, 8'h01, 8'h02});
        take(32'h7, 32'h5, 7'h55, 1'h0, 1'h0);
        issue({8'h1F, 8'h2A, 8'h03, 8'hF0});
        take(32'hF0, 32'hF000_0001, 7'h2A, 1'h0, 1'h0);
        issue({8'h1E, 8'h81, 8'h01, 8'h02});
        take(32'h7, 32'h5, 7'h01, 1'h1, 1'h0);
        issue({8'h0E, 8'h12, 8'h02, 8'h01});
        take(32'h5, 32'h7, 7'h12, 1'h0, 1'h1);
        issue({8'h0F, 8'hFF, 8'h01, 8'h33});
        take(32'h33, 32'h5, 7'h7F, 1'h1, 1'h1);
        // Multiple store against a slow taker fills the buffer
        reg_wr(sase_pkg::RegChannelCtl, 32'h2);
        reg_rd(sase_pkg::RegChannelCtl, 32'h2);
        slowMode <= 1'h1;
        issue({8'h1D, 8'h44, 8'h01, 8'h40});
        take(32'h40, 32'h5, 7'h44, 1'h0, 1'h0);
        take(32'h44, 32'h7, 7'h44, 1'h0, 1'h0);
        take(32'h48, 32'hF000_0001, 7'h44, 1'h0, 1'h0);
        slowMode <= 1'h0;
        reg_wr(sase_pkg::RegChannelCtl, 32'h1);
        issue({8'h1C, 8'hC4, 8'h02, 8'h03});
        take(32'hFFFF_FFFF, 32'h7, 7'h44, 1'h1, 1'h0);
        take(32'hFFFF_FFFF, 32'hF000_0001, 7'h44, 1'h1, 1'h0);
        check(73'(sase_store_taker_i.got.size()), 73'(0));
        // Sequencer idle with no words left once the run drained
        reg_rd(sase_pkg::RegExecState, 32'h0);
        reg_rd(sase_pkg::RegAluStatus, 32'h9);
        finish_test();
    end
endmodule // sase_exec_tb

// [bench/sase_store_taker.sv]
// Model of the memory bus and coprocessor that take store words
`timescale 1ns/1ns
module sase_store_taker
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic storeValid,
    output logic storeReady,
    input wire logic [31:0] storeAddr,
    input wire logic [31:0] storeData,
    input wire logic [6:0] storeCntl,
    input wire logic storeCop,
    input wire logic busHold
);
    // Accepted words in arrival order, read by the bench
    sase_pkg::sase_word_type got[$];
    // Phase for the slow taker
    logic [1:0] phase_r;

    // Phase runs every cycle once out of reset
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            phase_r <= 2'h0;
        else
            phase_r <= phase_r + 2'h1;
    end

    // Slow mode takes one cycle in four so the buffer fills and stalls
    assign storeReady = rst_n && (!slow || phase_r == 2'h3);

    // Record each word at the edge where it is handed over
    always @(posedge clk)
    begin
        if (rst_n && storeValid && storeReady)
            got.push_back({storeAddr, storeData, storeCntl, storeCop, busHold});
    end
endmodule // sase_store_taker

// [hw/sase_alu.sv]
// Shift-right and subtract datapath with flag generation
`timescale 1ns/1ns
module sase_alu
(
    input wire logic [31:0] first_source_operand,
    input wire logic [31:0] second_source_operand,
    input wire logic withBorrow,
    input wire logic carryIn,
    output logic [31:0] shiftResult,
    output logic [31:0] subResult,
    output logic [3:0] subFlags
);
    logic [32:0] sum; // Sum with carry out
    logic subCin; // Plain subtract uses +1 for two's complement

    // Zero-filled logical right shift by the low five bits
    assign shiftResult = first_source_operand >> second_source_operand[4:0];

    // A plus one's complement of B plus 1 or the carry flag
    assign subCin = withBorrow ? carryIn : 1'b1;
    assign sum = {1'b0, first_source_operand} + {1'b0, ~second_source_operand} + {32'h0000_0000, subCin};
    assign subResult = sum[31:0];

    // Flags: carry is the adder carry out, i.e. no borrow
    always_comb
    begin
        subFlags = 4'h0;
        subFlags[sase_pkg::FlagCarry] = sum[32];
        subFlags[sase_pkg::FlagZero] = (sum[31:0] == 32'h0000_0000);
        subFlags[sase_pkg::FlagNegative] = sum[31];
        // Signed overflow when operand signs differ and result sign leaves A
        subFlags[sase_pkg::FlagOverflow] = (first_source_operand[31] != second_source_operand[31]) && (sum[31] != first_source_operand[31]);
    end
endmodule // sase_alu

// [hw/sase_exec.sv]
// Execution unit for zero-fill shift, stores and subtracts
`timescale 1ns/1ns
module sase_exec
(
    input wire logic clk,
    input wire logic rst_n,
    // Instruction issue
    input wire logic instrValid,
    input wire logic [31:0] instrWord,
    output logic instrReady,
    // Register port
    input wire logic [8:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    // External store / coprocessor path
    output logic storeValid,
    input wire logic storeReady,
    output logic [31:0] storeAddr,
    output logic [31:0] storeData,
    output logic [6:0] storeCntl,
    output logic storeCop,
    output logic busHold
);
    // General registers
    logic [31:0] gpr_r [0:255];
    // ALU status flags and channel count-left field
    logic [3:0] aluStatus_r;
    logic [7:0] countLeft_r;
    // Sequencer
    sase_pkg::sase_state_type state_r;
    sase_pkg::sase_state_type state_nxt;
    logic [7:0] wordsLeft_r; // Words still to send after the current one
    logic [7:0] regIdx_r; // Register for the current word
    logic [31:0] addr_r; // Address (or second operand) for the current word
    logic [6:0] cntl_r; // Access control of the running store
    logic cop_r; // Coprocessor transfer
    logic lock_r; // Locked store
    logic multi_r; // Multiple store; keeps coprocessor words on the stepped address lane
    logic [31:0] copB_r; // Second operand for a single coprocessor transfer

    // Decoded instruction fields
    logic [7:0] opcode;
    logic [7:0] fieldTarget;
    logic [7:0] fieldA;
    logic [7:0] fieldB;
    logic literalPick;
    logic [31:0] first_source_operand;
    logic [31:0] second_source_operand;
    logic accept;
    logic isShift;
    logic isSub;
    logic isSubBorrow;
    logic isStore;
    logic isLocked;
    logic isMulti;
    logic anyStore;
    // ALU outputs
    logic [31:0] shiftResult;
    logic [31:0] subResult;
    logic [3:0] subFlags;
    // Buffer side
    sase_stream_if toBuf ();
    sase_pkg::sase_word_type headWord;
    logic sendDone;

    // Field split
    assign opcode = instrWord[sase_pkg::OpcodeHi:sase_pkg::OpcodeLo];
    assign fieldTarget = instrWord[sase_pkg::TargetHi:sase_pkg::TargetLo];
    assign fieldA = instrWord[sase_pkg::SrcAHi:sase_pkg::SrcALo];
    assign fieldB = instrWord[sase_pkg::SrcBHi:sase_pkg::SrcBLo];
    assign literalPick = instrWord[sase_pkg::LiteralPickBit];

    // Operand fetch
    assign first_source_operand = gpr_r[fieldA];
    assign second_source_operand = literalPick ? {24'h00_0000, fieldB} : gpr_r[fieldB];

    // Opcode pair match ignores the pick bit
    assign isShift = (opcode[7:1] == sase_pkg::OpShiftRightZeroFill);
    assign isSub = (opcode[7:1] == sase_pkg::OpMinus);
    assign isSubBorrow = (opcode[7:1] == sase_pkg::OpMinusWithBorrow);
    assign isStore = (opcode[7:1] == sase_pkg::OpStore);
    assign isLocked = (opcode[7:1] == sase_pkg::OpLockedWrite);
    assign isMulti = (opcode[7:1] == sase_pkg::OpMultiWordWrite);
    assign anyStore = isStore || isLocked || isMulti;
    assign accept = instrValid && instrReady;

    sase_alu u_alu
    (
        .first_source_operand(first_source_operand),
        .second_source_operand(second_source_operand),
        .withBorrow(isSubBorrow),
        .carryIn(aluStatus_r[sase_pkg::FlagCarry]),
        .shiftResult(shiftResult),
        .subResult(subResult),
        .subFlags(subFlags)
    );

    // Current word offered to the buffer
    always_comb
    begin
        toBuf.valid = (state_r == sase_pkg::SASE_SEND);
        toBuf.word.data = gpr_r[regIdx_r];
        // Single coprocessor transfers carry the second operand in the address lane
        toBuf.word.addr = (cop_r && !multi_r) ? copB_r : addr_r;
        toBuf.word.cntl = cntl_r;
        toBuf.word.cop = cop_r;
        toBuf.word.lock = lock_r;
    end
    assign sendDone = toBuf.valid && toBuf.ready && (wordsLeft_r == 8'h00);

    // Stall on a full buffer keeps the sequencer in SEND; nothing is lost
    sase_wbuf u_wbuf
    (
        .clk(clk),
        .rst_n(rst_n),
        .inPort(toBuf),
        .outValid(storeValid),
        .outReady(storeReady),
        .outWord(headWord)
    );
    assign storeAddr = headWord.addr;
    assign storeData = headWord.data;
    assign storeCntl = headWord.cntl;
    assign storeCop = headWord.cop;
    // Lock rides with each buffered word, so it stands for the whole access
    assign busHold = headWord.lock;

    // Next sequencer state
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            sase_pkg::SASE_IDLE:
            begin
                if (accept && anyStore)
                    state_nxt = sase_pkg::SASE_SEND;
            end
            sase_pkg::SASE_SEND:
            begin
                if (sendDone)
                    state_nxt = sase_pkg::SASE_IDLE;
            end
        endcase
    end

    // State and registered issue ready
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_r <= sase_pkg::SASE_IDLE;
            instrReady <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            // Issue only while idle; one instruction per cycle otherwise
            instrReady <= (state_nxt == sase_pkg::SASE_IDLE);
        end
    end

    // Store setup at accept and stepping per word taken
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wordsLeft_r <= 8'h00;
            regIdx_r <= 8'h00;
            addr_r <= 32'h0000_0000;
            cntl_r <= 7'h00;
            cop_r <= 1'b0;
            lock_r <= 1'b0;
            multi_r <= 1'b0;
            copB_r <= 32'h0000_0000;
        end
        else if (accept && anyStore)
        begin
            // Count is sampled once here; later writes do not alter the run
            wordsLeft_r <= isMulti ? countLeft_r : 8'h00;
            regIdx_r <= fieldA;
            addr_r <= second_source_operand;
            copB_r <= second_source_operand;
            cntl_r <= fieldTarget[sase_pkg::CntlHi-16:sase_pkg::CntlLo-16];
            cop_r <= fieldTarget[sase_pkg::CopSelBit-16];
            lock_r <= isLocked;
            multi_r <= isMulti;
        end
        else if (toBuf.valid && toBuf.ready && (wordsLeft_r != 8'h00))
        begin
            wordsLeft_r <= wordsLeft_r - 8'h01;
            regIdx_r <= regIdx_r + 8'h01;
            addr_r <= addr_r + sase_pkg::WordStep;
        end
    end

    // General registers: port writes, then results, which win a clash
    always_ff @(posedge clk)
    begin
        if (regWr && (regAddr[8] == sase_pkg::RegFileBase[8]))
            gpr_r[regAddr[7:0]] <= regWrData;
        if (accept && isShift)
            gpr_r[fieldTarget] <= shiftResult;
        else if (accept && (isSub || isSubBorrow))
            gpr_r[fieldTarget] <= subResult;
    end

    // ALU status: subtracts, else port writes, change it; stores leave it alone
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            aluStatus_r <= sase_pkg::AluStatusReset;
        else if (accept && (isSub || isSubBorrow))
            aluStatus_r <= subFlags;
        else if (regWr && (regAddr == sase_pkg::RegAluStatus))
            aluStatus_r <= regWrData[3:0];
    end

    // Channel count-left field, software written
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            countLeft_r <= sase_pkg::CountLeftReset;
        else if (regWr && (regAddr == sase_pkg::RegChannelCtl))
            countLeft_r <= regWrData[7:0];
    end

    // Read data valid in the cycle after the read strobe only
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            regRdData <= 32'h0000_0000;
        else if (!regRd)
            regRdData <= 32'h0000_0000;
        else if (regAddr[8] == sase_pkg::RegFileBase[8])
            regRdData <= gpr_r[regAddr[7:0]];
        else if (regAddr == sase_pkg::RegAluStatus)
            regRdData <= {28'h000_0000, aluStatus_r};
        else if (regAddr == sase_pkg::RegChannelCtl)
            regRdData <= {24'h00_0000, countLeft_r};
        else if (regAddr == sase_pkg::RegExecState)
            regRdData <= {16'h0000, wordsLeft_r, 7'h00, (state_r == sase_pkg::SASE_SEND)};
        else
            regRdData <= 32'h0000_0000; // Unmapped reads as zero
    end
endmodule // sase_exec

// [hw/sase_pkg.sv]
// Shared constants and types for the store and subtract execution block
package sase_pkg;
    // Instruction field positions
    localparam int OpcodeHi = 31;
    localparam int OpcodeLo = 24;
    localparam int TargetHi = 23;
    localparam int TargetLo = 16;
    localparam int SrcAHi = 15;
    localparam int SrcALo = 8;
    localparam int SrcBHi = 7;
    localparam int SrcBLo = 0;
    localparam int LiteralPickBit = 24;
    // Store control byte: coprocessor select and access control
    localparam int CopSelBit = 23;
    localparam int CntlHi = 22;
    localparam int CntlLo = 16;
    localparam int CntlWidth = 7;
    // Opcode pairs, upper seven bits only (bit 0 is the literal pick)
    localparam logic [6:0] OpShiftRightZeroFill = 7'h41;
    localparam logic [6:0] OpStore = 7'h0F;
    localparam logic [6:0] OpLockedWrite = 7'h07;
    localparam logic [6:0] OpMultiWordWrite = 7'h0E;
    localparam logic [6:0] OpMinus = 7'h12;
    localparam logic [6:0] OpMinusWithBorrow = 7'h16;
    // Register port map (indices, not byte addresses)
    localparam logic [8:0] RegFileBase = 9'h000;
    localparam logic [8:0] RegAluStatus = 9'h100;
    localparam logic [8:0] RegChannelCtl = 9'h101;
    localparam logic [8:0] RegExecState = 9'h102;
    // ALU status bit positions
    localparam int FlagCarry = 0;
    localparam int FlagZero = 1;
    localparam int FlagNegative = 2;
    localparam int FlagOverflow = 3;
    // Reset values
    localparam logic [3:0] AluStatusReset = 4'h0;
    localparam logic [7:0] CountLeftReset = 8'h00;
    // Address advance per word of a multiple store
    localparam logic [31:0] WordStep = 32'h0000_0004;

    // One outgoing bus word or coprocessor transfer
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic [CntlWidth-1:0] cntl;
        logic cop;
        logic lock;
    } sase_word_type;

    // Sequencer states
    typedef enum logic [1:0] {
        SASE_IDLE = 2'b01,
        SASE_SEND = 2'b10
    } sase_state_type;
endpackage

// [hw/sase_stream_if.sv]
// Valid/ready carrier for store words between the sequencer and buffer
`timescale 1ns/1ns
interface sase_stream_if;
    logic valid; // Word offered
    logic ready; // Word can be taken
    sase_pkg::sase_word_type word; // The word itself

    modport src
    (
        output valid,
        output word,
        input ready
    );
    modport snk
    (
        input valid,
        input word,
        output ready
    );
endinterface

// [hw/sase_wbuf.sv]
// Two-entry store buffer; outputs come straight from the head entry
`timescale 1ns/1ns
module sase_wbuf
(
    input wire logic clk,
    input wire logic rst_n,
    sase_stream_if.snk inPort,
    output logic outValid,
    input wire logic outReady,
    output sase_pkg::sase_word_type outWord
);
    sase_pkg::sase_word_type ent1_r; // Second entry
    logic [1:0] count_r; // Entries held, 0..2
    logic push; // Word enters
    logic pop; // Word leaves

    // Ready depends only on occupancy, so no combinational path to outReady
    assign inPort.ready = (count_r != 2'h2);
    assign push = inPort.valid && inPort.ready;
    assign pop = outValid && outReady;

    // Occupancy count and head valid
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            count_r <= 2'h0;
            outValid <= 1'b0;
        end
        else
        begin
            count_r <= count_r + {1'b0, push} - {1'b0, pop};
            outValid <= (count_r + {1'b0, push} - {1'b0, pop}) != 2'h0;
        end
    end

    // Entry data; head is cleared when it drains so lock drops with it
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            outWord <= '0;
            ent1_r <= '0;
        end
        else if (pop && push)
        begin
            // Shift and refill
            if (count_r == 2'h1)
                outWord <= inPort.word;
            else
            begin
                outWord <= ent1_r;
                ent1_r <= inPort.word;
            end
        end
        else if (pop)
        begin
            // Head drains; an empty buffer shows a zero word
            outWord <= (count_r == 2'h2) ? ent1_r : '0;
        end
        else if (push)
        begin
            if (count_r == 2'h0)
                outWord <= inPort.word;
            else
                ent1_r <= inPort.word;
        end
    end
endmodule // sase_wbuf
